// *** core/art_pkg.sv ***
// Constants and carrier types for the acquisition stop and hold trigger core
//==============================================================================
// Notes on behaviour
// - Posttrigger count equals programmed total minus programmed pretrigger count.
// - Stop trigger is armed only after the pretrigger count is stored.
// - While armed and the window is full, each new sample evicts the oldest.
// - After the stop trigger, samples are stored until the posttrigger count.
// - Digital stop source uses a selectable rising or falling edge.
// - Analog stop source uses the first comparator rising edge after arming.
// - Stop source mux covers terminals, sync lines, stars, events, counters, subsystems.
// - Stop trigger can drive terminals, sync lines, backplane lines, differential star.
// - Every function terminal resets as input; it drives only when set output.
// - Sample clock is held off while the hold trigger is active.
// - Hold trigger active level is programmable high or low.
// - Hold source mux covers terminals, sync lines, stars, counters, subsystem holds.
// - Analog hold source pauses at one comparator level, resumes at the other.
// - Hold trigger acts purely on level; its edges do nothing.
// - Hold trigger can drive terminals, sync lines, backplane star, differential star.
// - Each channel has its own range: 10, 5, 2 or 1 volt bipolar.
// - Each channel has its own converter word and queue, sampled together.
// - Conversion results are 16-bit codes.
// - Queues lose nothing silently; host drains by stream port or register reads.
// - A pretriggered acquisition begins on the start trigger, pin or software.
// - Stop trigger is not retriggerable; done holds until reconfigured.
package art_pkg;

  //============================================================================
  // Widths
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 32;
  localparam int SAMPLE_W    = 16;
  localparam int CNT_W       = 16;
  localparam int SEL_W       = 6;
  localparam int SRC_W       = 37;
  localparam int MUX_N       = 36;
  localparam int ANALOG_BIT  = 36;

  //============================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CMD      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TOTAL    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PRE      = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_STOP_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_HOLD_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PFI_DIR  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PFI_SEL  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_SYNC_RT  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_BKP_RT   = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_RANGE    = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_COUNT    = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_DATA     = 8'h40;

  //============================================================================
  // Field positions
  localparam int B_REF_EN    = 0;
  localparam int B_FINITE    = 1;
  localparam int B_PAUSE_EN  = 2;
  localparam int B_START     = 0;
  localparam int B_RECONF    = 1;
  localparam int B_POLARITY  = 6;
  localparam int B_ANALOG    = 7;
  localparam int B_STAR_EN   = 8;
  localparam int B_DC_EN     = 9;
  localparam int B_DC_SEL    = 10;
  localparam int B_ARMED     = 3;
  localparam int B_TRIGGERED = 4;
  localparam int B_DONE      = 5;
  localparam int B_OVERFLOW  = 6;
  localparam int B_CFG_ERR   = 7;
  localparam int B_HOLDING   = 8;

  //============================================================================
  // Reset values
  localparam logic [CNT_W-1:0] RST_TOTAL = 16'h0000;
  localparam logic [CNT_W-1:0] RST_PRE   = 16'h0000;
  localparam logic [SEL_W-1:0] RST_SEL   = 6'h00;
  localparam logic [15:0]      RST_PFI   = 16'h0000;

  //============================================================================
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_ARMED, ST_POST, ST_DONE} art_state_t;

  typedef enum logic [1:0] {RANGE_10V, RANGE_5V, RANGE_2V, RANGE_1V} art_range_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } art_bus_req_t;

  // Trigger sources, LSB first: terminals, sync lines, stars, events, subsystems
  typedef struct packed {
    logic        analog_cmp;
    logic        digital_in_hold_trigger;
    logic        digital_out_hold_trigger;
    logic        analog_out_hold_trigger;
    logic        analog_out_begin_trigger;
    logic        digital_out_begin_trigger;
    logic        digital_in_stop_trigger;
    logic        counter_gate;
    logic        counter_output;
    logic        change_detect;
    logic        backplane_star;
    logic [1:0]  differential_star_line;
    logic [7:0]  sync_bus_line;
    logic [15:0] programmable_function_terminal;
  } art_trig_src_t;

  typedef struct packed {
    logic [15:0] pfi_out;
    logic [15:0] pfi_oe_n;
    logic [7:0]  sync_out;
    logic [7:0]  sync_oe_n;
    logic [7:0]  bkp_out;
    logic [7:0]  bkp_oe_n;
    logic        star_out;
    logic        star_oe_n;
    logic        differential_star_output;
  } art_route_out_t;

endpackage : art_pkg

// *** core/art_trigger_core.sv ***
// Stop and hold trigger control with per-channel sample queues
`timescale 1ns/1ps
`default_nettype none

module art_trigger_core #(
  parameter int CHANNELS = 4,
  parameter int DEPTH    = 256
) (
  input  wire logic                                  clk,
  input  wire logic                                  rst,
  input  wire art_pkg::art_bus_req_t                 bus,
  output logic [art_pkg::DATA_W-1:0]                 rdata,
  input  wire art_pkg::art_trig_src_t                trig_src,
  input  wire logic                                  start_trigger,
  input  wire logic                                  sample_tick,
  input  wire logic [CHANNELS*art_pkg::SAMPLE_W-1:0] adc_data,
  output logic                                       sample_clk_enable,
  output logic [2*CHANNELS-1:0]                      range_sel,
  output logic                                       dma_valid,
  input  wire logic                                  dma_ready,
  output logic [CHANNELS*art_pkg::SAMPLE_W-1:0]      dma_data,
  output var art_pkg::art_route_out_t                route,
  output logic                                       acq_done
);
  import art_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  //============================================================================
  // Parameter checks
  if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
    $error("CHANNELS must be 1 to 16");
  end
  if (DEPTH < 2 || DEPTH > 32768 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 32768");
  end

  //============================================================================
  // State
  typedef struct packed {
    art_state_t                   state;
    logic [SRC_W-1:0]             sync1;
    logic [SRC_W-1:0]             sync2;
    logic                         ref_prev;
    logic                         clk_en;
    logic                         ref_en;
    logic                         finite;
    logic                         pause_en;
    logic [CNT_W-1:0]             total;
    logic [CNT_W-1:0]             pre;
    logic [SEL_W-1:0]             ref_sel;
    logic                         ref_fall;
    logic                         ref_analog;
    logic [SEL_W-1:0]             hold_sel;
    logic                         hold_low;
    logic                         hold_analog;
    logic [15:0]                  pfi_dir;
    logic [15:0]                  pfi_sel;
    logic [7:0]                   sync_dir;
    logic [7:0]                   sync_sel;
    logic [7:0]                   bkp_en;
    logic                         star_en;
    logic                         dc_en;
    logic                         dc_sel;
    logic [2*CHANNELS-1:0]        range;
    logic                         triggered;
    logic                         overflow;
    logic                         cfg_err;
    logic                         holding;
    logic [CNT_W-1:0]             pre_cnt;
    logic [CNT_W-1:0]             post_cnt;
    logic [CHANNELS-1:0][AW-1:0]  wptr;
    logic [CHANNELS-1:0][AW-1:0]  rptr;
    logic [CHANNELS-1:0][CW-1:0]  cnt;
    logic [DATA_W-1:0]            rdata;
    logic                         dma_valid;
    logic [CHANNELS*SAMPLE_W-1:0] dma_data;
    art_route_out_t               route;
  } art_core_state_t;

  art_core_state_t s;
  art_core_state_t next_s;

  logic [SAMPLE_W-1:0] mem [CHANNELS][DEPTH];

  logic                ref_lvl;
  logic                ref_now;
  logic                ref_edge;
  logic                hold_lvl;
  logic                hold;
  logic                running;
  logic                store_now;
  logic                trig_acc;
  logic                cfg_ok;
  logic                start_req;
  logic                reconf;
  logic                rd_hit;
  logic [3:0]          rd_ch;
  logic                all_full;
  logic                dma_load;
  logic [CNT_W-1:0]    post_target;
  logic [CHANNELS-1:0] host_pop;
  logic [CHANNELS-1:0] drop;
  logic [CHANNELS-1:0] pop_any;
  logic [CHANNELS-1:0] push;
  logic [CHANNELS-1:0] lost;
  logic [ADDR_W-1:0]   rd_ofs;

  //============================================================================
  // Next-state logic
  always_comb begin
    next_s = s;
    // Two-stage synchroniser on every outside source
    next_s.sync1 = trig_src;
    next_s.sync2 = s.sync1;

    // Source selection; out-of-range selects read as low
    ref_lvl  = (s.ref_sel < SEL_W'(MUX_N)) ? s.sync2[s.ref_sel] : 1'b0;
    hold_lvl = s.hold_analog ? s.sync2[ANALOG_BIT]
             : ((s.hold_sel < SEL_W'(MUX_N)) ? s.sync2[s.hold_sel] : 1'b0);
    // Edge chosen by inverting the level; analog always rising
    ref_now  = s.ref_analog ? s.sync2[ANALOG_BIT] : (ref_lvl ^ s.ref_fall);
    ref_edge = ref_now & ~s.ref_prev;
    next_s.ref_prev = ref_now;
    // Hold is a pure level with programmable sense
    hold = s.pause_en & (hold_lvl ^ s.hold_low);
    next_s.holding = hold;

    running   = (s.state == ST_PRE) || (s.state == ST_ARMED) || (s.state == ST_POST);
    next_s.clk_en = running & ~hold;
    post_target = s.ref_en ? (s.total - s.pre) : s.total;
    cfg_ok = s.ref_en ? (s.finite && s.total != 16'h0000 && s.pre <= s.total
                         && 32'(s.total) <= DEPTH)
                      : (!s.finite || s.total != 16'h0000);

    // Stored samples only: held-off clocks never reach the counters
    store_now = sample_tick & ~hold &
                (((s.state == ST_PRE) && (s.pre_cnt < s.pre)) ||
                 ((s.state == ST_ARMED) && (s.pre != 16'h0000)) ||
                 ((s.state == ST_POST) && (!s.finite || s.post_cnt < post_target)));

    // Register port decode
    rd_ofs    = bus.addr - OFS_DATA;
    rd_ch     = rd_ofs[5:2];
    rd_hit    = bus.rd && (bus.addr >= OFS_DATA) && (rd_ofs[1:0] == 2'b00)
             && (32'(rd_ofs[ADDR_W-1:2]) < CHANNELS);
    start_req = start_trigger | (bus.wr && bus.addr == OFS_CMD && bus.wdata[B_START]);
    reconf    = bus.wr && bus.addr == OFS_CMD && bus.wdata[B_RECONF];
    next_s.rdata = '0;

    // Queue bookkeeping, one lane per channel
    all_full = 1'b1;
    for (int c = 0; c < CHANNELS; c++) begin
      if (s.cnt[c] == '0) all_full = 1'b0;
    end
    dma_load = (~s.dma_valid | dma_ready) & all_full & ~rd_hit;
    next_s.dma_valid = dma_load | (s.dma_valid & ~dma_ready);
    for (int c = 0; c < CHANNELS; c++) begin
      host_pop[c] = rd_hit && (32'(rd_ch) == c) && (s.cnt[c] != '0);
      // Oldest sample leaves when the pretrigger window is full
      drop[c]    = store_now && (s.state == ST_ARMED) && (CNT_W'(s.cnt[c]) >= s.pre)
                   && !host_pop[c] && !dma_load;
      pop_any[c] = host_pop[c] | dma_load | drop[c];
      lost[c]    = store_now && (32'(s.cnt[c]) == DEPTH) && !pop_any[c];
      push[c]    = store_now && !lost[c];
      next_s.cnt[c]  = s.cnt[c] + CW'(push[c]) - CW'(pop_any[c]);
      next_s.wptr[c] = s.wptr[c] + AW'(push[c]);
      next_s.rptr[c] = s.rptr[c] + AW'(pop_any[c]);
      if (host_pop[c]) begin
        next_s.rdata = {{(DATA_W-SAMPLE_W){1'b0}}, mem[c][s.rptr[c]]};
      end
      if (dma_load) begin
        next_s.dma_data[c*SAMPLE_W +: SAMPLE_W] = mem[c][s.rptr[c]];
      end
    end

    // Register reads
    if (bus.rd && !rd_hit) begin
      case (bus.addr)
        OFS_CTRL: begin
          next_s.rdata[B_REF_EN]   = s.ref_en;
          next_s.rdata[B_FINITE]   = s.finite;
          next_s.rdata[B_PAUSE_EN] = s.pause_en;
        end
        OFS_TOTAL: next_s.rdata[CNT_W-1:0] = s.total;
        OFS_PRE: next_s.rdata[CNT_W-1:0] = s.pre;
        OFS_STOP_CFG: next_s.rdata[7:0] = {s.ref_analog, s.ref_fall, s.ref_sel};
        OFS_HOLD_CFG: next_s.rdata[7:0] = {s.hold_analog, s.hold_low, s.hold_sel};
        OFS_PFI_DIR: next_s.rdata[15:0] = s.pfi_dir;
        OFS_PFI_SEL: next_s.rdata[15:0] = s.pfi_sel;
        OFS_SYNC_RT: next_s.rdata[15:0] = {s.sync_sel, s.sync_dir};
        OFS_BKP_RT: next_s.rdata[10:0] = {s.dc_sel, s.dc_en, s.star_en, s.bkp_en};
        OFS_RANGE: next_s.rdata[2*CHANNELS-1:0] = s.range;
        OFS_STATUS: begin
          next_s.rdata[2:0]         = s.state;
          next_s.rdata[B_ARMED]     = (s.state == ST_ARMED);
          next_s.rdata[B_TRIGGERED] = s.triggered;
          next_s.rdata[B_DONE]      = (s.state == ST_DONE);
          next_s.rdata[B_OVERFLOW]  = s.overflow;
          next_s.rdata[B_CFG_ERR]   = s.cfg_err;
          next_s.rdata[B_HOLDING]   = s.holding;
        end
        OFS_COUNT: next_s.rdata = {s.post_cnt, s.pre_cnt};
        default: next_s.rdata = '0;
      endcase
    end

    // Register writes; configuration is frozen while acquiring
    if (bus.wr && !running) begin
      case (bus.addr)
        OFS_CTRL: begin
          next_s.ref_en   = bus.wdata[B_REF_EN];
          next_s.finite   = bus.wdata[B_FINITE];
          next_s.pause_en = bus.wdata[B_PAUSE_EN];
        end
        OFS_TOTAL: next_s.total = bus.wdata[CNT_W-1:0];
        OFS_PRE: next_s.pre = bus.wdata[CNT_W-1:0];
        OFS_STOP_CFG: begin
          next_s.ref_sel    = bus.wdata[SEL_W-1:0];
          next_s.ref_fall   = bus.wdata[B_POLARITY];
          next_s.ref_analog = bus.wdata[B_ANALOG];
        end
        OFS_HOLD_CFG: begin
          next_s.hold_sel    = bus.wdata[SEL_W-1:0];
          next_s.hold_low    = bus.wdata[B_POLARITY];
          next_s.hold_analog = bus.wdata[B_ANALOG];
        end
        OFS_PFI_DIR: next_s.pfi_dir = bus.wdata[15:0];
        OFS_PFI_SEL: next_s.pfi_sel = bus.wdata[15:0];
        OFS_SYNC_RT: {next_s.sync_sel, next_s.sync_dir} = bus.wdata[15:0];
        OFS_BKP_RT: begin
          next_s.bkp_en  = bus.wdata[7:0];
          next_s.star_en = bus.wdata[B_STAR_EN];
          next_s.dc_en   = bus.wdata[B_DC_EN];
          next_s.dc_sel  = bus.wdata[B_DC_SEL];
        end
        OFS_RANGE: next_s.range = bus.wdata[2*CHANNELS-1:0];
        default: ;
      endcase
    end
    // Sticky flags cleared by writing one; a new event below wins
    if (bus.wr && bus.addr == OFS_STATUS) begin
      if (bus.wdata[B_OVERFLOW]) next_s.overflow = 1'b0;
      if (bus.wdata[B_CFG_ERR]) next_s.cfg_err = 1'b0;
    end

    // Acquisition sequence
    trig_acc = 1'b0;
    case (s.state)
      ST_IDLE: begin
        if (start_req && cfg_ok) begin
          next_s.state     = s.ref_en ? ST_PRE : ST_POST;
          next_s.pre_cnt   = '0;
          next_s.post_cnt  = '0;
          next_s.triggered = 1'b0;
          next_s.cnt       = '0;
          next_s.wptr      = '0;
          next_s.rptr      = '0;
          next_s.dma_valid = 1'b0;
        end else if (start_req) begin
          next_s.cfg_err = 1'b1;
        end
      end
      ST_PRE: begin
        if (store_now) next_s.pre_cnt = s.pre_cnt + 16'h0001;
        // Edges before the window is filled are ignored
        if (s.pre_cnt >= s.pre) next_s.state = ST_ARMED;
      end
      ST_ARMED: begin
        if (ref_edge) begin
          trig_acc         = 1'b1;
          next_s.triggered = 1'b1;
          next_s.state     = ST_POST;
        end
      end
      ST_POST: begin
        if (store_now) next_s.post_cnt = s.post_cnt + 16'h0001;
        if (s.finite && s.post_cnt >= post_target) next_s.state = ST_DONE;
      end
      ST_DONE: ;
      default: next_s.state = ST_IDLE;
    endcase
    if (reconf) next_s.state = ST_IDLE;
    if ((|lost) && s.state != ST_ARMED) next_s.overflow = 1'b1;

    // Output routing; terminals drive only when set as outputs
    next_s.route.pfi_out  = (next_s.pfi_sel & {16{hold}}) | (~next_s.pfi_sel & {16{trig_acc}});
    next_s.route.pfi_oe_n = ~next_s.pfi_dir;
    next_s.route.sync_out = (next_s.sync_sel & {8{hold}}) | (~next_s.sync_sel & {8{trig_acc}});
    next_s.route.sync_oe_n = ~next_s.sync_dir;
    next_s.route.bkp_out   = {8{trig_acc}};
    next_s.route.bkp_oe_n  = ~next_s.bkp_en;
    next_s.route.star_out  = hold;
    next_s.route.star_oe_n = ~next_s.star_en;
    next_s.route.differential_star_output = next_s.dc_en & (next_s.dc_sel ? hold : trig_acc);
  end

  //============================================================================
  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s                <= '0;
      s.state          <= ST_IDLE;
      s.total          <= RST_TOTAL;
      s.pre            <= RST_PRE;
      s.ref_sel        <= RST_SEL;
      s.hold_sel       <= RST_SEL;
      s.pfi_dir        <= RST_PFI;
      s.route.pfi_oe_n <= ~RST_PFI;
      s.route.sync_oe_n <= 8'hFF;
      s.route.bkp_oe_n <= 8'hFF;
      s.route.star_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Sample memory, one queue per channel
  always_ff @(posedge clk) begin
    for (int c = 0; c < CHANNELS; c++) begin
      if (push[c]) mem[c][s.wptr[c]] <= adc_data[c*SAMPLE_W +: SAMPLE_W];
    end
  end

  // Outputs
  assign rdata             = s.rdata;
  assign sample_clk_enable = s.clk_en;
  assign range_sel         = s.range;
  assign dma_valid         = s.dma_valid;
  assign dma_data          = s.dma_data;
  assign route             = s.route;
  assign acq_done          = (s.state == ST_DONE);

  //============================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_post_total: assert property (
    s.state == ST_DONE && s.ref_en |-> s.post_cnt == s.total - s.pre)
    else $error("posttrigger count differs from total minus pretrigger");
  a_arm_after_pre: assert property (
    s.state == ST_ARMED && $past(s.state) == ST_PRE |-> s.pre_cnt == s.pre)
    else $error("armed before pretrigger count reached");
  a_pre_ignores_trig: assert property (
    s.state == ST_PRE |=> s.state != ST_POST)
    else $error("stop trigger accepted before arming");
  a_window_bound: assert property (
    s.state == ST_ARMED |-> CNT_W'(s.cnt[0]) <= s.pre)
    else $error("pretrigger window exceeds its count");
  a_drop_oldest: assert property (
    s.state == ST_ARMED && store_now && CNT_W'(s.cnt[0]) == s.pre && !host_pop[0] && !dma_load
    |=> s.cnt[0] == $past(s.cnt[0]))
    else $error("full window did not evict oldest sample");
  a_post_stop: assert property (
    s.state == ST_POST && s.finite && s.post_cnt >= post_target
    |=> s.state == ST_DONE || s.state == ST_IDLE)
    else $error("acquisition did not stop at posttrigger count");
  a_analog_edge: assert property (
    s.state == ST_ARMED && s.ref_analog && s.sync2[ANALOG_BIT] && !s.ref_prev && !reconf
    |=> s.state == ST_POST ##1 s.triggered)
    else $error("comparator rising edge did not stop acquisition");
  a_done_sticky: assert property (
    s.state == ST_DONE && !reconf |=> s.state == ST_DONE)
    else $error("done state left without reconfiguration");
  a_hold_gate: assert property (
    hold |=> !sample_clk_enable)
    else $error("sample clock enabled while held");
  a_hold_no_count: assert property (
    hold && s.state == ST_PRE |=> s.pre_cnt == $past(s.pre_cnt))
    else $error("held-off sample was counted");
  a_sync_depth: assert property (
    ##2 s.sync2 == $past(trig_src, 2))
    else $error("source not delayed by two stages");
  a_pfi_input: assert property (
    $past(s.pfi_dir) == 16'h0000 && $past(bus.wr) == 1'b0 |-> route.pfi_oe_n == 16'hFFFF)
    else $error("terminal driven while set as input");

endmodule : art_trigger_core

`default_nettype wire

// *** test/art_partner.sv ***
// Sample source and stalling host sink facing the trigger core
`timescale 1ns/1ps
`default_nettype none
module art_partner (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   stall,
  input  wire logic   dma_valid,
  output logic        sample_tick,
  output logic [63:0] adc_data,
  output logic        dma_ready,
  output logic [15:0] words
);
  logic [1:0]  div;
  logic [15:0] seq;
  // All channels converted at one instant, 16-bit codes
  assign adc_data  = {seq + 16'h0003, seq + 16'h0002, seq + 16'h0001, seq};
  assign dma_ready = !stall;
  // Tick every fourth cycle; count words taken by the host
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div         <= 2'h0;
      seq         <= 16'h0000;
      sample_tick <= 1'b0;
      words       <= 16'h0000;
    end else begin
      div         <= div + 2'h1;
      sample_tick <= (div == 2'h3);
      if (sample_tick) seq <= seq + 16'h0004;
      if (dma_valid && dma_ready) words <= words + 16'h0001;
    end
  end
endmodule : art_partner
`default_nettype wire

// *** test/test_ai_reference_pause_trigger.sv ***
// Self-checking bench for the stop and hold trigger core
`timescale 1ns/1ps
`default_nettype none
module test_ai_reference_pause_trigger;
  import art_pkg::*;
  logic clk, rst, start_trigger, sample_tick, stall, dma_valid, dma_ready;
  logic sample_clk_enable, acq_done;
  art_bus_req_t bus;
  art_trig_src_t trig_src;
  art_route_out_t route;
  logic [DATA_W-1:0] rdata, v;
  logic [63:0] adc_data, dma_data;
  logic [7:0] range_sel;
  logic [15:0] words;
  int fails = 0, check_count = 0;
  //============================================================================
  // Clock, design and far side
  initial begin clk = 0; forever #2.5 clk = ~clk; end
  art_trigger_core dut_u (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .trig_src(trig_src),
    .start_trigger(start_trigger), .sample_tick(sample_tick), .adc_data(adc_data),
    .sample_clk_enable(sample_clk_enable), .range_sel(range_sel), .dma_valid(dma_valid),
    .dma_ready(dma_ready), .dma_data(dma_data), .route(route), .acq_done(acq_done));
  art_partner far_u (.clk(clk), .rst(rst), .stall(stall), .dma_valid(dma_valid),
    .sample_tick(sample_tick), .adc_data(adc_data), .dma_ready(dma_ready), .words(words));
  // Sticky watch on the routed stop pulse and on stream lane order
  logic seen_stop, lane_bad;
  always @(posedge clk) begin
    if (rst) begin
      seen_stop <= 1'b0;
      lane_bad  <= 1'b0;
    end else begin
      if (route.bkp_out[0] && !route.bkp_oe_n[0]) seen_stop <= 1'b1;
      if (dma_valid && dma_ready && dma_data[63:16] !== {dma_data[15:0] + 16'h0003,
          dma_data[15:0] + 16'h0002, dma_data[15:0] + 16'h0001}) lane_bad <= 1'b1;
    end
  end
  //============================================================================
  // Bus cycles, checks and verdict
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1;
    @(posedge clk); bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk); bus.addr <= a; bus.rd <= 1'b1;
    @(posedge clk); bus.rd <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin fails++; $display("Error %s expected %h seen %h", n, e, g); end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic edge_on(input int b, input logic l);
    @(posedge clk); trig_src[b] <= l; repeat (4) @(posedge clk);
  endtask : edge_on
  //============================================================================
  // Scenarios
  task automatic t_reset;
    chk("pfi_oe_n", 32'h0000FFFF, 32'(route.pfi_oe_n));
    rd(8'h3C); chk("unmapped", 32'h0, v);
    wr(OFS_RANGE, 32'h000000E4); @(posedge clk); chk("range", 32'hE4, 32'(range_sel));
    $display("reset test over");
  endtask : t_reset
  task automatic t_stop;
    trig_src[16] <= 1'b1; stall <= 1'b1; wr(OFS_BKP_RT, 32'h1);
    wr(OFS_TOTAL, 32'h4); wr(OFS_PRE, 32'h2); wr(OFS_STOP_CFG, 32'h50);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CMD, 32'h1); edge_on(16, 1'b0);
    repeat (20) @(posedge clk); rd(OFS_STATUS);
    chk("armed", 32'(ST_ARMED), 32'(v[2:0]));
    chk("early stop", 32'h0, 32'(seen_stop));
    edge_on(16, 1'b1); rd(OFS_STATUS);
    chk("rising ignored", 32'(ST_ARMED), 32'(v[2:0]));
    edge_on(16, 1'b0);
    for (int i = 0; i < 200 && acq_done !== 1'b1; i++) @(posedge clk);
    chk("acq_done", 32'h1, 32'(acq_done));
    if (acq_done !== 1'b1) conclude();
    chk("routed stop", 32'h1, 32'(seen_stop));
    rd(OFS_COUNT); chk("count", 32'h00020002, v);
    edge_on(16, 1'b1); edge_on(16, 1'b0); rd(OFS_STATUS);
    chk("still done", 32'(ST_DONE), 32'(v[2:0]));
    stall <= 1'b0; repeat (10) @(posedge clk);
    // Stream stage word, then the two-sample window, then two posttrigger samples
    chk("host words", 32'h5, 32'(words));
    chk("lanes", 32'h0, 32'(lane_bad));
    wr(OFS_CMD, 32'h2); $display("stop test over");
  endtask : t_stop
  task automatic t_analog;
    wr(OFS_PRE, 32'h0); wr(OFS_STOP_CFG, 32'h80); wr(OFS_CMD, 32'h1);
    repeat (4) @(posedge clk); edge_on(36, 1'b1);
    for (int i = 0; i < 200 && acq_done !== 1'b1; i++) @(posedge clk);
    rd(OFS_STATUS); chk("analog stop", 32'h34, 32'(v[5:0]));
    trig_src[36] <= 1'b0; wr(OFS_CMD, 32'h2); $display("analog stop test over");
  endtask : t_analog
  task automatic t_hold;
    trig_src[17] <= 1'b1; wr(OFS_HOLD_CFG, 32'h51); wr(OFS_TOTAL, 32'h64); wr(OFS_CTRL, 32'h6);
    @(posedge clk); start_trigger <= 1'b1; @(posedge clk); start_trigger <= 1'b0;
    repeat (5) @(posedge clk); chk("run", 32'h1, 32'(sample_clk_enable));
    edge_on(17, 1'b0); chk("held", 32'h0, 32'(sample_clk_enable));
    edge_on(17, 1'b1); chk("resumed", 32'h1, 32'(sample_clk_enable));
    wr(OFS_CMD, 32'h2); wr(OFS_HOLD_CFG, 32'h80);
    @(posedge clk); start_trigger <= 1'b1; @(posedge clk); start_trigger <= 1'b0;
    repeat (5) @(posedge clk); edge_on(36, 1'b1);
    chk("analog held", 32'h0, 32'(sample_clk_enable));
    edge_on(36, 1'b0); chk("analog resumed", 32'h1, 32'(sample_clk_enable));
    wr(OFS_CMD, 32'h2); $display("hold test over");
  endtask : t_hold
  initial begin
    rst = 1; bus = '0; trig_src = '0; start_trigger = 0; stall = 0;
    repeat (2) @(posedge clk); rst <= 0;
    t_reset(); t_stop(); t_analog(); t_hold(); conclude();
  end
endmodule : test_ai_reference_pause_trigger
`default_nettype wire
